/* hdl/fmq_pkg.sv */
// Constants shared by the file and memory query command block.
// Assumes a 32-bit APB bus; every register takes one aligned word.
package fmq_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;  // Start strobe
	localparam logic [7:0] OFF_STAT   = 8'h04;  // Status word, length, busy, done
	localparam logic [7:0] OFF_HDR    = 8'h08;  // Class, instruction, P1, P2
	localparam logic [7:0] OFF_BODYA  = 8'h0C;  // Body bytes 0..3
	localparam logic [7:0] OFF_BODYB  = 8'h10;  // Body bytes 4..5
	localparam logic [7:0] OFF_CMDLEN = 8'h14;  // Body length, protection flag
	localparam logic [7:0] OFF_CUR    = 8'h18;  // Current file index and valid
	localparam logic [7:0] OFF_RESP   = 8'h20;  // Reply words 0x20..0x34
	localparam logic [7:0] OFF_FTAB   = 8'h40;  // File table 0x40..0x7C
	localparam int         RESP_WORDS = 6;
	localparam int         RESP_BYTES = 21;
	localparam int         NFILES     = 4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_START = 0;
	localparam int STAT_BUSY  = 24;
	localparam int STAT_DONE  = 25;
	localparam int LEN_PROT   = 8;
	localparam int FT_VALID   = 31;
	localparam int FT_RECORD  = 24;
	// ----------------------------------------
	// Command coding
	// ----------------------------------------
	localparam logic [7:0]  CLA_QUERY = 8'h8C;
	localparam logic [7:0]  INS_QUERY = 8'h5F;
	localparam logic [7:0]  P1_CUR    = 8'h00;
	localparam logic [7:0]  P1_REF    = 8'h01;
	localparam logic [7:0]  TAG_REF   = 8'h51;
	localparam logic [7:0]  TAG_PROT  = 8'h85;
	localparam logic [7:0]  TAG_TMPLH = 8'h7F;
	localparam logic [7:0]  TAG_TMPLL = 8'h78;
	localparam logic [7:0]  TAG_TOTAL = 8'h81;
	localparam logic [7:0]  TAG_REMAIN = 8'h82;
	localparam logic [7:0]  TAG_EXIST = 8'h83;
	localparam logic [4:0]  SFI_MAX   = 5'h1E;
	// ----------------------------------------
	// Status words
	// ----------------------------------------
	localparam logic [15:0] SW_OK     = 16'h9000;
	localparam logic [15:0] SW_CLA    = 16'h6E00;
	localparam logic [15:0] SW_INS    = 16'h6D00;
	localparam logic [15:0] SW_P1P2   = 16'h6A86;
	localparam logic [15:0] SW_LEN    = 16'h6700;
	localparam logic [15:0] SW_DATA   = 16'h6A80;
	localparam logic [15:0] SW_NOFILE = 16'h6A82;
	localparam logic [15:0] SW_NOCUR  = 16'h6986;
	localparam logic [15:0] SW_STRUCT = 16'h6981;
	localparam logic [15:0] SW_PROT   = 16'h6988;
	localparam logic [15:0] SW_RESET  = 16'h0000;
	// Controller states, one-hot
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_CHECK  = 4'b0010,
		S_DIVIDE = 4'b0100,
		S_BUILD  = 4'b1000
	} state_t;
endpackage

/* hdl/count_tlv.sv */
// Encodes one count as a short tag-length-value object, shortest form.
// Pure combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
module count_tlv (
	// Object request
	input  wire logic [7:0]  tag,
	input  wire logic [31:0] value,
	// Encoded object, first byte in the top lane
	output logic      [47:0] obj,
	output logic      [2:0]  obj_len
);
	// ----------------------------------------
	// Shortest big-endian value
	// ----------------------------------------
	// Zero still needs one value byte so the object is never empty
	always_comb begin
		if (value[31:24] != 8'h00) begin
			obj     = {tag, 8'h04, value};
			obj_len = 3'h6;
		end else if (value[23:16] != 8'h00) begin
			obj     = {tag, 8'h03, value[23:0], 8'h00};
			obj_len = 3'h5;
		end else if (value[15:8] != 8'h00) begin
			obj     = {tag, 8'h02, value[15:0], 16'h0000};
			obj_len = 3'h4;
		end else begin
			obj     = {tag, 8'h01, value[7:0], 24'h000000};
			obj_len = 3'h3;
		end
	end
endmodule

/* hdl/file_memory_query_cmd.sv */
// File and memory query command handler with APB register access.
// Assumes firmware loads the file table and the command, then starts it.
//
// Overview of operation
// - Accept only class 8C, instruction 5F
// - P1 00 current file, 01 reference
// - P2 bits pick counts; upper bits zero
// - Reply holds only requested count objects
// - Reply wrapped in template tag 7F78
// - Counts under tags 81, 82, 83
// - Byte count is payload only
// - Remaining records assume maximum record size
// - Successful query sets the current file
// - One byte short id, two full id
// - Success 9000, otherwise standard error words
// - Protected body comes inside tag 85
// - Record counts only for record files
`timescale 1ns/1ps
module file_memory_query_cmd (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import fmq_pkg::*;
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	state_t      st_q;                       // Controller state
	logic [31:0] hdr_q;                      // Class, ins, P1, P2
	logic [47:0] body_q;                     // Command body bytes
	logic [2:0]  nc_q;                       // Body length
	logic        prot_q;                     // Body is protected
	logic [31:0] tab_q [NFILES][4];          // File table
	logic [1:0]  cur_idx_q;                  // Current file
	logic        cur_valid_q;                // A current file exists
	logic [1:0]  hit_q;                      // File addressed by the query
	logic [15:0] sw_q;                       // Status word
	logic [4:0]  rlen_q;                     // Reply length in bytes
	logic [7:0]  resp_q [RESP_BYTES];        // Reply image
	logic        done_q;                     // Last command finished
	logic [31:0] quo_q;                      // Division quotient
	logic [31:0] rem_q;                      // Division remainder
	logic [4:0]  cnt_q;                      // Division step
	// Command fields
	logic [7:0] cla, ins, p1, p2;
	assign {cla, ins, p1, p2} = hdr_q;
	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic wr_en, setup, mapped, start;
	logic [7:0] off;
	assign off    = paddr[7:0];
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pwrite & mapped;
	assign mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00)
		&& (off <= OFF_CUR || (off >= OFF_RESP && off < OFF_FTAB + 8'h40)
		&& !(off > OFF_RESP + 8'h14 && off < OFF_FTAB));
	assign pready  = 1'b1;                   // No wait states
	assign pslverr = psel & penable & ~mapped;
	assign start   = wr_en && off == OFF_CTRL && pwdata[CTRL_START] && st_q == S_IDLE;

	// Byte of the body by position
	function automatic logic [7:0] body_byte(input logic [47:0] b, input logic [2:0] i);
		body_byte = b[8 * (5 - int'(i)) +: 8];
	endfunction
	// Read data registered in the setup cycle so the data output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= 32'h00000000;
			// Unmapped or aliased addresses read zero, never a register
			if (!mapped)
				prdata <= 32'h00000000;
			else if (off == OFF_STAT)
				prdata <= {6'h00, done_q, st_q != S_IDLE, 3'h0, rlen_q, sw_q};
			else if (off == OFF_HDR)
				prdata <= hdr_q;
			else if (off == OFF_BODYA)
				prdata <= body_q[47:16];
			else if (off == OFF_BODYB)
				prdata <= {16'h0000, body_q[15:0]};
			else if (off == OFF_CMDLEN)
				prdata <= {23'h000000, prot_q, 5'h00, nc_q};
			else if (off == OFF_CUR)
				prdata <= {23'h000000, cur_valid_q, 6'h00, cur_idx_q};
			else if (off >= OFF_FTAB)
				prdata <= tab_q[off[5:4]][off[3:2]];
			else if (off >= OFF_RESP && off < OFF_RESP + 8'h18)
				for (int b = 0; b < 4; b++)
					if (int'(off[4:2]) * 4 + b < RESP_BYTES)
						prdata[31 - 8 * b -: 8] <= resp_q[int'(off[4:2]) * 4 + b];
		end
	end
	// Command and table registers; frozen while a query runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_q  <= 32'h00000000;
			body_q <= 48'h000000000000;
			nc_q   <= 3'h0;
			prot_q <= 1'b0;
			for (int i = 0; i < NFILES; i++)
				for (int j = 0; j < 4; j++)
					tab_q[i][j] <= 32'h00000000;
		end else if (wr_en && st_q == S_IDLE) begin
			if (off == OFF_HDR)
				hdr_q <= pwdata;
			if (off == OFF_BODYA)
				body_q[47:16] <= pwdata;
			if (off == OFF_BODYB)
				body_q[15:0] <= pwdata[15:0];
			if (off == OFF_CMDLEN) begin
				nc_q <= (pwdata[2:0] > 3'h6) ? 3'h6 : pwdata[2:0];
				prot_q <= pwdata[LEN_PROT];
			end
			if (off >= OFF_FTAB)
				tab_q[off[5:4]][off[3:2]] <= pwdata;
		end
	end
	// ----------------------------------------
	// Command checking and file lookup
	// ----------------------------------------
	logic [15:0] chk_sw;
	logic [1:0]  chk_hit;
	always_comb begin
		logic [2:0] o;
		logic [7:0] t, l, v;
		logic       found;
		o       = prot_q ? 3'h2 : 3'h0;
		t       = body_byte(body_q, o);
		l       = body_byte(body_q, o + 3'h1);
		v       = body_byte(body_q, o + 3'h2);
		found   = 1'b0;
		chk_hit = cur_idx_q;
		chk_sw  = SW_OK;
		if (cla != CLA_QUERY || (ins != INS_QUERY && cla == CLA_QUERY)) begin
			chk_sw = (cla != CLA_QUERY) ? SW_CLA : SW_INS;
		end else if ((p1 != P1_CUR && p1 != P1_REF) || p2[7:3] != 5'h00) begin
			chk_sw = SW_P1P2;
		end else if (p1 == P1_CUR) begin
			if (nc_q != 3'h0)
				chk_sw = SW_LEN;
			else if (!cur_valid_q)
				chk_sw = SW_NOCUR;
			found = cur_valid_q;
		end else if (prot_q && (body_byte(body_q, 3'h0) != TAG_PROT
			|| body_byte(body_q, 3'h1) != {5'h00, nc_q - 3'h2})) begin
			chk_sw = SW_PROT;
		end else if (t != TAG_REF || (l != 8'h01 && l != 8'h02)
			|| {5'h00, nc_q} != {5'h00, o} + 8'h02 + l) begin
			chk_sw = SW_DATA;
		end else if (l == 8'h01 && (v[2:0] != 3'h0 || v[7:3] == 5'h00 || v[7:3] > SFI_MAX)) begin
			chk_sw = SW_DATA;
		end else begin
			// Short id matches the table's short id, full id the file id
			for (int i = NFILES - 1; i >= 0; i--)
				if (tab_q[i][0][FT_VALID] && ((l == 8'h01 && tab_q[i][0][20:16] == v[7:3])
					|| (l == 8'h02 && tab_q[i][0][15:0]
					== {v, body_byte(body_q, o + 3'h3)}))) begin
					found   = 1'b1;
					chk_hit = 2'(i);
				end
			if (!found)
				chk_sw = SW_NOFILE;
		end
		// Record counts only make sense for record files
		if (chk_sw == SW_OK && found && p2[2:1] != 2'b00 && !tab_q[chk_hit][0][FT_RECORD])
			chk_sw = SW_STRUCT;
	end

	// ----------------------------------------
	// Reply image
	// ----------------------------------------
	logic [47:0] obj [3];
	logic [2:0]  olen [3];
	logic [31:0] cnt_val [3];
	logic [7:0]  img [RESP_BYTES];
	logic [4:0]  img_len;
	assign cnt_val[0] = tab_q[hit_q][1];                  // Payload bytes only
	assign cnt_val[1] = quo_q;
	assign cnt_val[2] = {16'h0000, tab_q[hit_q][3][15:0]};
	count_tlv u_total (.tag(TAG_TOTAL), .value(cnt_val[0]), .obj(obj[0]), .obj_len(olen[0]));
	count_tlv u_remain (.tag(TAG_REMAIN), .value(cnt_val[1]), .obj(obj[1]), .obj_len(olen[1]));
	count_tlv u_exist (.tag(TAG_EXIST), .value(cnt_val[2]), .obj(obj[2]), .obj_len(olen[2]));
	// Packs the selected objects back to back behind the template header
	always_comb begin
		logic [4:0] pos;
		pos = 5'h03;
		for (int i = 0; i < RESP_BYTES; i++)
			img[i] = 8'h00;
		img[0] = TAG_TMPLH;
		img[1] = TAG_TMPLL;
		for (int k = 0; k < 3; k++)
			if (p2[k]) begin
				for (int j = 0; j < 6; j++)
					if (j < int'(olen[k]))
						img[int'(pos) + j] = obj[k][47 - 8 * j -: 8];
				pos = pos + {2'b00, olen[k]};
			end
		img[2]  = {3'h0, pos - 5'h03};
		img_len = (p2[2:0] == 3'b000) ? 5'h00 : pos;
	end

	// ----------------------------------------
	// Controller
	// ----------------------------------------
	// Free bytes per maximum record, by 32 shift-subtract steps
	logic [32:0] rem_n;
	logic [15:0] maxrec;
	assign maxrec = tab_q[hit_q][3][31:16];
	assign rem_n  = {rem_q, quo_q[31]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= S_IDLE;
			hit_q  <= 2'h0;
			quo_q  <= 32'h00000000;
			rem_q  <= 32'h00000000;
			cnt_q  <= 5'h00;
			sw_q   <= SW_RESET;
			rlen_q <= 5'h00;
			done_q <= 1'b0;
			for (int i = 0; i < RESP_BYTES; i++)
				resp_q[i] <= 8'h00;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (start) begin
						st_q   <= S_CHECK;
						done_q <= 1'b0;
					end
				end
				S_CHECK: begin
					hit_q <= chk_hit;
					quo_q <= (tab_q[chk_hit][2] > tab_q[chk_hit][1]) ? 32'h00000000
						: tab_q[chk_hit][1] - tab_q[chk_hit][2];
					rem_q <= 32'h00000000;
					cnt_q <= 5'h00;
					if (chk_sw != SW_OK) begin
						sw_q   <= chk_sw;
						rlen_q <= 5'h00;
						for (int i = 0; i < RESP_BYTES; i++)
							resp_q[i] <= 8'h00;
						done_q <= 1'b1;
						st_q   <= S_IDLE;
					end else begin
						st_q <= S_DIVIDE;
					end
				end
				S_DIVIDE: begin
					// A zero maximum size yields zero remaining records
					if (maxrec == 16'h0000) begin
						quo_q <= 32'h00000000;
						st_q  <= S_BUILD;
					end else begin
						cnt_q <= cnt_q + 5'h01;
						if (rem_n >= {17'h00000, maxrec}) begin
							rem_q <= 32'(rem_n - {17'h00000, maxrec});
							quo_q <= {quo_q[30:0], 1'b1};
						end else begin
							rem_q <= rem_n[31:0];
							quo_q <= {quo_q[30:0], 1'b0};
						end
						if (cnt_q == 5'h1F)
							st_q <= S_BUILD;
					end
				end
				S_BUILD: begin
					for (int i = 0; i < RESP_BYTES; i++)
						resp_q[i] <= (img_len == 5'h00) ? 8'h00 : img[i];
					rlen_q <= img_len;
					sw_q   <= SW_OK;
					done_q <= 1'b1;
					st_q   <= S_IDLE;
				end
			endcase
		end
	end
	// Current file follows every successful query
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_idx_q   <= 2'h0;
			cur_valid_q <= 1'b0;
		end else if (st_q == S_BUILD) begin
			cur_idx_q   <= hit_q;
			cur_valid_q <= 1'b1;
		end else if (wr_en && off == OFF_CUR && st_q == S_IDLE) begin
			cur_idx_q   <= pwdata[1:0];
			cur_valid_q <= pwdata[8];
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_class_check: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_CHECK && cla != CLA_QUERY |=> sw_q == SW_CLA && done_q)
		else $error("wrong class not refused");
	a_p1_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_CHECK && cla == CLA_QUERY && ins == INS_QUERY && p1 > P1_REF
		|=> sw_q == SW_P1P2 && rlen_q == 5'h00)
		else $error("reserved P1 accepted");
	a_p2_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_CHECK && cla == CLA_QUERY && ins == INS_QUERY && p2[7:3] != 5'h00
		|=> sw_q == SW_P1P2)
		else $error("reserved P2 bits accepted");
	a_only_total: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(done_q) && sw_q == SW_OK && p2[2:0] == 3'b001
		|-> resp_q[3] == TAG_TOTAL && rlen_q == 5'h03 + {2'b00, resp_q[4][2:0]} + 5'h02)
		else $error("unrequested object in reply");
	a_template_hdr: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(done_q) && sw_q == SW_OK && rlen_q != 5'h00
		|-> resp_q[0] == TAG_TMPLH && resp_q[1] == TAG_TMPLL && resp_q[2] == {3'h0, rlen_q - 5'h03})
		else $error("template header wrong");
	a_current_set: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_BUILD |=> cur_valid_q && cur_idx_q == $past(hit_q) && sw_q == SW_OK)
		else $error("current file not updated");
	a_error_nobody: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(done_q) && sw_q != SW_OK |-> rlen_q == 5'h00)
		else $error("error reply carries a body");
	a_struct_check: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_BUILD |-> !(p2[2:1] != 2'b00 && !tab_q[hit_q][0][FT_RECORD]))
		else $error("record counts on transparent file");
	a_div_bound: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_CHECK && chk_sw == SW_OK |=> ##[1:33] st_q == S_BUILD)
		else $error("division did not finish in 33 cycles");
	a_prot_wrapper: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == S_CHECK && cla == CLA_QUERY && ins == INS_QUERY && p1 == P1_REF
		&& p2[7:3] == 5'h00 && prot_q && body_byte(body_q, 3'h0) != TAG_PROT |=> sw_q == SW_PROT)
		else $error("protected body without tag 85 accepted");
endmodule

/* dv/fmq_terminal.sv */
// Terminal model: loads query frames into the command block over APB.
// Assumes it is the only APB master and shares the block's clock.
`timescale 1ns/1ps
module fmq_terminal (
	// Clock
	input  wire logic        pclk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	import fmq_pkg::*;
	// ----------------------------------------
	// Bus state
	// ----------------------------------------
	logic [31:0] rdata; // Word taken at the last access edge
	logic        rerr;  // Error flag taken at that edge
	// Idle bus from time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 32'h0;
		pwdata  = 32'h0;
	end
	// One transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {24'h0, a};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No wait count assumed, the bench watchdog cuts a hang
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Loads header, body and length, then starts the query
	task automatic send_cmd(input logic [31:0] hdr, input logic [47:0] body,
		input logic [2:0] nc, input logic prot);
		xfer(1'b1, OFF_HDR, hdr);
		xfer(1'b1, OFF_BODYA, body[47:16]);
		xfer(1'b1, OFF_BODYB, {16'h0, body[15:0]});
		// Zero length stands for an absent length field
		xfer(1'b1, OFF_CMDLEN, {23'h0, prot, 5'h0, nc});
		xfer(1'b1, OFF_CTRL, 32'h1);
	endtask
endmodule

/* dv/file_memory_query_cmd_tb_top.sv */
// Self-checking bench for the file and memory query command block.
// Assumes the terminal model drives APB; expectations come from bench tables.
`timescale 1ns/1ps
module file_memory_query_cmd_tb_top;
	import fmq_pkg::*;
	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	logic        pclk;           // Bus clock
	logic        presetn;        // Reset, low active
	logic        psel;           // APB select
	logic        penable;        // APB enable
	logic        pwrite;         // APB direction
	logic [31:0] paddr;          // APB address
	logic [31:0] pwdata;         // APB write data
	logic [31:0] prdata;         // APB read data
	logic        pready;         // APB ready
	logic        pslverr;        // APB error
	int          num_errors;     // Mismatch count
	int          tests_run;      // Compare count
	integer      seed;           // Random seed
	logic [31:0] cap   [NFILES]; // Payload capacity
	logic [31:0] used  [NFILES]; // Used bytes
	logic [15:0] mrec  [NFILES]; // Max record size
	logic [15:0] exist [NFILES]; // Existing records
	logic [15:0] fid   [NFILES]; // Full identifier
	logic [4:0]  sid   [NFILES]; // Short identifier
	logic        rec   [NFILES]; // Record structure
	logic [7:0]  exp_b [24];     // Expected reply, zero padded
	int          exp_n;          // Expected reply length
	logic [31:0] cur_exp;        // Expected current file word
	file_memory_query_cmd uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);
	fmq_terminal term (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
	);
	// ----------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Run needs about two thousand cycles; allow fifteen times that
	initial begin
		#300000;
		num_errors++;
		print_verdict();
	end
	task automatic print_verdict();
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// ----------------------------------------
	// Expectation helpers
	// ----------------------------------------
	function automatic logic [47:0] sref(input int f);
		sref = {16'h5101, sid[f], 3'b000, 24'h0};
	endfunction
	function automatic logic [47:0] fref(input int f);
		fref = {16'h5102, fid[f], 16'h0};
	endfunction
	task automatic clear_exp();
		foreach (exp_b[j]) exp_b[j] = 8'h0;
		exp_n = 0;
	endtask
	// Appends one count in shortest big-endian form
	task automatic add_obj(input logic [7:0] tag, input logic [31:0] v);
		int n;
		n = (v > 32'hFFFFFF) ? 4 : (v > 32'hFFFF) ? 3 : (v > 32'hFF) ? 2 : 1;
		exp_b[exp_n] = tag;
		exp_b[exp_n + 1] = 8'(n);
		exp_n += 2;
		for (int i = n - 1; i >= 0; i--) begin
			exp_b[exp_n] = v[8*i +: 8];
			exp_n++;
		end
	endtask
	// Reply for a successful query of file f with request bits p2
	task automatic expect_reply(input int f, input logic [2:0] p2);
		logic [31:0] rem;
		clear_exp();
		exp_n = 3;
		// Free space over full-size records, none when overfull
		rem = (used[f] > cap[f] || mrec[f] == 16'h0) ? 32'h0 : (cap[f] - used[f]) / mrec[f];
		if (p2[0]) add_obj(8'h81, cap[f]);
		if (p2[1]) add_obj(8'h82, rem);
		if (p2[2]) add_obj(8'h83, {16'h0, exist[f]});
		exp_b[0] = 8'h7F;
		exp_b[1] = 8'h78;
		exp_b[2] = 8'(exp_n - 3);
		if (p2 == 3'b000) clear_exp();
	endtask
	// Polls completion, then checks status, length, reply and current file
	task automatic finish_cmd(input logic [15:0] sw);
		int k;
		k = 0;
		do begin
			term.xfer(1'b0, OFF_STAT, 32'h0);
			k++;
		end while (term.rdata[STAT_DONE] !== 1'b1 && k < 100);
		check32("done", 32'h1, {31'h0, term.rdata[STAT_DONE]});
		check32("status", {16'h0, sw}, {16'h0, term.rdata[15:0]});
		check32("length", 32'(exp_n), {27'h0, term.rdata[20:16]});
		for (int w = 0; w < RESP_WORDS; w++) begin
			term.xfer(1'b0, OFF_RESP + 8'(4*w), 32'h0);
			check32("reply", {exp_b[4*w], exp_b[4*w+1], exp_b[4*w+2], exp_b[4*w+3]},
				term.rdata);
		end
		term.xfer(1'b0, OFF_CUR, 32'h0);
		check32("current", cur_exp, term.rdata);
	endtask
	task automatic ok_case(input int f, input logic [31:0] hdr, input logic [47:0] body,
		input logic [2:0] nc, input logic prot);
		term.send_cmd(hdr, body, nc, prot);
		expect_reply(f, hdr[2:0]);
		cur_exp = {23'h0, 1'b1, 6'h0, 2'(f)};
		finish_cmd(16'h9000);
	endtask
	// Refused query: no reply, current file unchanged
	task automatic err_case(input logic [31:0] hdr, input logic [47:0] body,
		input logic [2:0] nc, input logic prot, input logic [15:0] sw);
		term.send_cmd(hdr, body, nc, prot);
		clear_exp();
		finish_cmd(sw);
	endtask
	task automatic load_file(input int f);
		logic [7:0] a;
		a = OFF_FTAB + 8'(16*f);
		term.xfer(1'b1, a, {1'b1, 6'h0, rec[f], 3'h0, sid[f], fid[f]});
		term.xfer(1'b1, a + 8'h4, cap[f]);
		term.xfer(1'b1, a + 8'h8, used[f]);
		term.xfer(1'b1, a + 8'hC, {mrec[f], exist[f]});
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		num_errors = 0;
		tests_run = 0;
		seed = 32'h440B25E2;
		presetn = 1'b0;
		cur_exp = 32'h0;
		for (int i = 0; i < NFILES; i++) begin
			fid[i] = 16'h0110 + 16'(i);
			sid[i] = 5'(i + 1);
			rec[i] = (i != 0);
		end
		// Last file sits on the highest short id
		sid[3] = 5'h1E;
		cap = '{32'h3E8, 32'h12345, 32'h10, 32'h1000000};
		used = '{32'hA, 32'h45, 32'h20, 32'h0};
		mrec = '{16'h0, 16'h100, 16'h4, 16'h0};
		exist = '{16'h0, 16'h5, 16'h1234, 16'h0};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		term.xfer(1'b0, OFF_STAT, 32'h0);
		check32("stat reset", 32'h0, term.rdata);
		term.xfer(1'b0, 8'h1C, 32'h0);
		check32("slverr", 32'h1, {31'h0, term.rerr});
		for (int i = 0; i < NFILES; i++) load_file(i);
		// Above the table, so a decode that wraps would show file data
		term.xfer(1'b0, 8'h9C, 32'h0);
		check32("unmapped", 32'h0, term.rdata);
		err_case(32'h8C5F0001, 48'h0, 3'd0, 1'b0, 16'h6986);
		// Transparent file gets bytes only, record files all counts
		ok_case(0, 32'h8C5F0101, sref(0), 3'd3, 1'b0);
		for (int i = 1; i < NFILES; i++) begin
			ok_case(i, 32'h8C5F0107, sref(i), 3'd3, 1'b0);
		end
		ok_case(3, 32'h8C5F0007, 48'h0, 3'd0, 1'b0);
		ok_case(1, 32'h8C5F0103, fref(1), 3'd4, 1'b0);
		ok_case(0, 32'h8C5F0101, 48'h850351010800, 3'd5, 1'b1);
		err_case(32'h0C5F0101, sref(0), 3'd3, 1'b0, 16'h6E00);
		err_case(32'h8C5E0101, sref(0), 3'd3, 1'b0, 16'h6D00);
		err_case(32'h8C5F0201, sref(0), 3'd3, 1'b0, 16'h6A86);
		err_case(32'h8C5F0109, sref(0), 3'd3, 1'b0, 16'h6A86);
		err_case(32'h8C5F0101, 48'h5101F8000000, 3'd3, 1'b0, 16'h6A80);
		err_case(32'h8C5F0101, 48'h510109000000, 3'd3, 1'b0, 16'h6A80);
		err_case(32'h8C5F0102, sref(0), 3'd3, 1'b0, 16'h6981);
		err_case(32'h8C5F0001, sref(0), 3'd3, 1'b0, 16'h6700);
		err_case(32'h8C5F0101, 48'h860351010800, 3'd5, 1'b1, 16'h6988);
		// Random counts shrinking toward zero cover every value length
		for (int r = 0; r < 12; r++) begin
			cap[1] = {$random(seed)} >> (3*r);
			used[1] = {$random(seed)} >> (3*r + 1);
			mrec[1] = 16'({$random(seed)} >> (2*r));
			exist[1] = 16'($random(seed));
			load_file(1);
			ok_case(1, {24'h8C5F01, 5'h0, 3'({$random(seed)} % 7 + 1)}, fref(1), 3'd4,
				1'b0);
		end
		// No count requested: success with an empty reply
		ok_case(1, 32'h8C5F0100, fref(1), 3'd4, 1'b0);
		// Reset in mid-query: header frozen while busy, then status and current file cleared
		term.send_cmd(32'h8C5F0107, sref(2), 3'd3, 1'b0);
		term.xfer(1'b1, OFF_HDR, 32'h0);
		term.xfer(1'b0, OFF_HDR, 32'h0);
		check32("hdr busy", 32'h8C5F0107, term.rdata);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		term.xfer(1'b0, OFF_STAT, 32'h0);
		check32("stat reset", 32'h0, term.rdata);
		term.xfer(1'b0, OFF_CUR, 32'h0);
		check32("cur reset", 32'h0, term.rdata);
		print_verdict();
	end
endmodule
